// >>> dtec_top.sv
// Dual timer/event counter: an 8-bit and a 16-bit counter behind classic Wishbone.
// Assumes byte registers in the low data lane, pins synchronous to clk_i.
// Behaviour
// - Counter 0: 8-bit up, pin or clk/4
// - Counter 1: 16-bit up, pin or clk/4
// - Control bit 3 picks rising or falling
// - Control bit 4 is run bit
// - Bits 7:6 pick event, timer, pulse mode
// - Control bits 0-2 and 5 read zero
// - Counter 0 write preloads, read is live
// - Low write buffers; high write loads preload
// - High read returns live, captures low
// - Wrap reloads preload and sets flag
// - Pulse mode times level, then clears run
// - One measurement until run set again
// - Pulse mode starts on edges, wraps normally
// - Event and timer never self-clear run
// - Overflow drives the wake-up output
// - Cleared enable blocks the interrupt request
// - Stopped preload write loads counter too
// - Counter 0 data and counter 1 high reads freeze the count clock
// - Event counts pin edges, timer clk/4
//
// Implementation choice: the Wishbone slave port.
`include "dtec_consts.svh"
module dtec_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic counter0_input_pin_i,
  input wire logic counter1_input_pin_i,
  output logic irq_o,
  output logic wakeup_o,
  output dtec_pkg::dtec_mode_t counter0_mode_o
);
  import dtec_pkg::*;
  dtec_cnt_if #(.W(8)) c0 ();   // Counter 0 bundle
  dtec_cnt_if #(.W(16)) c1 ();  // Counter 1 bundle
  logic [7:0] ctrl0;            // Counter 0 control
  logic [7:0] ctrl1;            // Counter 1 control
  logic [7:0] interrupt_control_register;             // Enables and flags
  logic [7:0] pre0;             // Counter 0 preload
  logic [15:0] pre1;            // Counter 1 preload
  logic [7:0] low_buf;          // Counter 1 low byte buffer
  logic req;                    // New access this cycle
  logic wr;                     // Write with low lane
  logic rd;                     // Read request
  logic ld0;
  logic ld1;
  logic [7:0] next_rdata;

  // One request per access; ack follows one cycle later
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = req & wb_we_i & wb_sel_i[0];
  assign rd = req & ~wb_we_i;

  // Drive the interface bundles from the control and preload registers, load strobes and read decode
  assign c0.mode = ctrl0[`DTEC_BIT_MODE_HI:`DTEC_BIT_MODE_LO];
  assign c0.edge_select = ctrl0[`DTEC_BIT_EDGE];
  assign c0.run_bit = ctrl0[`DTEC_BIT_RUN];
  assign c0.preload = pre0;
  assign c0.load_stb = ld0;
  assign c0.freeze = rd & (wb_adr_i == `DTEC_ADR_C0_DATA);
  assign c1.mode = ctrl1[`DTEC_BIT_MODE_HI:`DTEC_BIT_MODE_LO];
  assign c1.edge_select = ctrl1[`DTEC_BIT_EDGE];
  assign c1.run_bit = ctrl1[`DTEC_BIT_RUN];
  assign c1.preload = pre1;
  assign c1.load_stb = ld1;
  assign c1.freeze = rd & (wb_adr_i == `DTEC_ADR_C1_HIGH);

  // Stopped-counter loads follow a preload write by one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ld0 <= 1'b0;
      ld1 <= 1'b0;
    end else begin
      ld0 <= wr & (wb_adr_i == `DTEC_ADR_C0_DATA) & ~ctrl0[`DTEC_BIT_RUN];
      ld1 <= wr & (wb_adr_i == `DTEC_ADR_C1_HIGH) & ~ctrl1[`DTEC_BIT_RUN];
    end
  end

  // Counter cores
  dtec_core #(.W(8)) u_c0 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(counter0_input_pin_i),
    .cif(c0)
  );
  dtec_core #(.W(16)) u_c1 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(counter1_input_pin_i),
    .cif(c1)
  );

  // Preload registers and low byte buffer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre0 <= 8'h00;
      pre1 <= 16'h0000;
      low_buf <= 8'h00;
    end else begin
      if (wr && wb_adr_i == `DTEC_ADR_C0_DATA) begin
        pre0 <= wb_dat_i[7:0];
      end
      if (wr && wb_adr_i == `DTEC_ADR_C1_HIGH) begin
        pre1 <= {wb_dat_i[7:0], low_buf};
      end
      if (wr && wb_adr_i == `DTEC_ADR_C1_LOW) begin
        low_buf <= wb_dat_i[7:0];
      end else if (rd && wb_adr_i == `DTEC_ADR_C1_HIGH) begin
        low_buf <= c1.count[7:0];
      end
    end
  end

  // Control registers; measurement end clears run unless software sets it now
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl0 <= `DTEC_CTRL_RESET;
      ctrl1 <= `DTEC_CTRL_RESET;
    end else begin
      if (wr && wb_adr_i == `DTEC_ADR_C0_CTRL) begin
        ctrl0 <= wb_dat_i[7:0] & `DTEC_CTRL_MASK;
      end else if (c0.run_clear) begin
        ctrl0[`DTEC_BIT_RUN] <= 1'b0;
      end
      if (wr && wb_adr_i == `DTEC_ADR_C1_CTRL) begin
        ctrl1 <= wb_dat_i[7:0] & `DTEC_CTRL_MASK;
      end else if (c1.run_clear) begin
        ctrl1[`DTEC_BIT_RUN] <= 1'b0;
      end
    end
  end

  // Interrupt control: flags set by overflow win over a software write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      interrupt_control_register <= 8'h00;
    end else begin
      if (wr && wb_adr_i == `DTEC_ADR_INTERRUPT_CONTROL_REGISTER) begin
        interrupt_control_register <= wb_dat_i[7:0] & `DTEC_INTERRUPT_CONTROL_REGISTER_MASK;
      end
      if (c0.overflow) begin
        interrupt_control_register[`DTEC_BIT_T0_FLAG] <= 1'b1;
      end
      if (c1.overflow) begin
        interrupt_control_register[`DTEC_BIT_T1_FLAG] <= 1'b1;
      end
    end
  end

  // Read multiplexer
  always_comb begin
    case (wb_adr_i)
      `DTEC_ADR_C0_DATA: next_rdata = c0.count;
      `DTEC_ADR_C0_CTRL: next_rdata = ctrl0;
      `DTEC_ADR_C1_HIGH: next_rdata = c1.count[15:8];
      `DTEC_ADR_C1_LOW: next_rdata = low_buf;
      `DTEC_ADR_C1_CTRL: next_rdata = ctrl1;
      `DTEC_ADR_INTERRUPT_CONTROL_REGISTER: next_rdata = interrupt_control_register;
      default: next_rdata = 8'h00;
    endcase
  end

  // Bus answer, one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (rd) begin
        wb_dat_o <= {24'h00_0000, next_rdata};
      end
    end
  end

  // Interrupt request, wake-up and mode outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
      wakeup_o <= 1'b0;
      counter0_mode_o <= DTEC_MODE_NONE;
    end else begin
      irq_o <= (interrupt_control_register[`DTEC_BIT_T0_FLAG] & interrupt_control_register[`DTEC_BIT_T0_EN])
             | (interrupt_control_register[`DTEC_BIT_T1_FLAG] & interrupt_control_register[`DTEC_BIT_T1_EN]);
      wakeup_o <= c0.overflow | c1.overflow;
      counter0_mode_o <= dtec_mode_t'(c0.mode);
    end
  end

  // Acknowledge is a single-cycle pulse
  chk_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
  // Unimplemented control bits never hold a one
  chk_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    ((ctrl0 | ctrl1) & ~`DTEC_CTRL_MASK) == 8'h00)
    else $error("reserved control bit set");
  // Counter 1 wrap raises its request flag
  chk_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
    c1.overflow |=> interrupt_control_register[`DTEC_BIT_T1_FLAG])
    else $error("overflow flag missed");
  // Interrupt output stays low with both enables clear
  chk_irq_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    !interrupt_control_register[`DTEC_BIT_T0_EN] && !interrupt_control_register[`DTEC_BIT_T1_EN] |=> !irq_o)
    else $error("irq with enables clear");
  // Counter 0 wrap reaches the wake-up output
  chk_wake_src: assert property (@(posedge clk_i) disable iff (rst_i)
    c0.overflow |=> wakeup_o)
    else $error("no wake-up on overflow");
  // Outside pulse mode only a write may drop the run bit
  chk_run_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    (c0.mode != DTEC_MODE_PULSE && c0.run_bit && !wr) |=> c0.run_bit)
    else $error("run cleared without write");
  // High byte write pairs with the buffered low byte
  chk_high_load: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && wb_adr_i == `DTEC_ADR_C1_HIGH) |=> pre1 == {$past(wb_dat_i[7:0]), $past(low_buf)})
    else $error("preload pair wrong");
  // Stopped counter 0 takes the preload two edges after the write
  chk_stop_load: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && wb_adr_i == `DTEC_ADR_C0_DATA && !c0.run_bit) |=> ##1 c0.count == pre0)
    else $error("stopped counter not loaded");

  // Stopped high byte write, then the load strobe, then the loaded count
  sequence s_c1_stop_wr;
    wr && wb_adr_i == `DTEC_ADR_C1_HIGH && !c1.run_bit;
  endsequence
  sequence s_c1_loaded;
    ld1 ##1 (c1.count == pre1);
  endsequence
  // Stopped counter 1 takes the paired preload
  chk_stop_load1: assert property (@(posedge clk_i) disable iff (rst_i)
    s_c1_stop_wr |=> s_c1_loaded)
    else $error("stopped counter 1 not loaded");
  // A preload write to a running counter leaves the count alone
  chk_run_preload: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && wb_adr_i == `DTEC_ADR_C0_DATA && c0.run_bit) |=> !ld0)
    else $error("running counter loaded by write");

  // Every taken request is acknowledged on the next edge
  chk_ack_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    req |=> wb_ack_o)
    else $error("taken request not acknowledged");
  // No acknowledge without a request taken one edge before
  chk_ack_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    !req |=> !wb_ack_o)
    else $error("acknowledge without request");
  // Only the low byte lane carries read data
  chk_dat_upper: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_dat_o[31:8] == 24'h00_0000)
    else $error("upper read lanes not zero");
  // Read data holds between reads
  chk_rdata_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !rd |=> wb_dat_o == $past(wb_dat_o))
    else $error("read data moved without read");
  // Addresses outside the register file read back zero
  chk_unmapped_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && (wb_adr_i < `DTEC_ADR_C0_DATA || wb_adr_i > `DTEC_ADR_INTERRUPT_CONTROL_REGISTER))
    |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");

  // Counter 0 data reads return the live count
  chk_c0_read_live: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && wb_adr_i == `DTEC_ADR_C0_DATA) |=> wb_dat_o[7:0] == $past(c0.count))
    else $error("counter 0 read not live");
  // Counter 0 data writes go to the preload
  chk_c0_preload: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && wb_adr_i == `DTEC_ADR_C0_DATA) |=> pre0 == $past(wb_dat_i[7:0]))
    else $error("counter 0 preload not written");
  // Counter 0 preload changes only by its own write
  chk_c0_pre_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr && wb_adr_i == `DTEC_ADR_C0_DATA) |=> pre0 == $past(pre0))
    else $error("counter 0 preload changed");
  // Counter 1 high byte read returns the live high count
  chk_c1_high_live: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && wb_adr_i == `DTEC_ADR_C1_HIGH) |=> wb_dat_o[7:0] == $past(c1.count[15:8]))
    else $error("counter 1 high read not live");
  // The same read captures the live low count
  chk_low_capture: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && wb_adr_i == `DTEC_ADR_C1_HIGH) |=> low_buf == $past(c1.count[7:0]))
    else $error("low count not captured");
  // Low byte writes fill the buffer
  chk_low_fill: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && wb_adr_i == `DTEC_ADR_C1_LOW) |=> low_buf == $past(wb_dat_i[7:0]))
    else $error("low buffer not written");
  // The buffer changes only by a low write or a high read
  chk_low_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    (!(wr && wb_adr_i == `DTEC_ADR_C1_LOW) && !(rd && wb_adr_i == `DTEC_ADR_C1_HIGH))
    |=> low_buf == $past(low_buf))
    else $error("low buffer changed");
  // Counter 1 preload changes only on a high byte write
  chk_c1_pre_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr && wb_adr_i == `DTEC_ADR_C1_HIGH) |=> pre1 == $past(pre1))
    else $error("counter 1 preload changed");

  // Counter 0 control writes keep only the implemented bits
  chk_c0_ctrl_wr: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && wb_adr_i == `DTEC_ADR_C0_CTRL)
    |=> ctrl0 == ($past(wb_dat_i[7:0]) & `DTEC_CTRL_MASK))
    else $error("counter 0 control write wrong");
  // Counter 1 control writes keep only the implemented bits
  chk_c1_ctrl_wr: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && wb_adr_i == `DTEC_ADR_C1_CTRL)
    |=> ctrl1 == ($past(wb_dat_i[7:0]) & `DTEC_CTRL_MASK))
    else $error("counter 1 control write wrong");
  // Interrupt control holds only enables and flags
  chk_interrupt_control_register_bits: assert property (@(posedge clk_i) disable iff (rst_i)
    (interrupt_control_register & ~`DTEC_INTERRUPT_CONTROL_REGISTER_MASK) == 8'h00)
    else $error("unused interrupt control bit set");
  // Counter 0 wrap raises its request flag
  chk_c0_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    c0.overflow |=> interrupt_control_register[`DTEC_BIT_T0_FLAG])
    else $error("counter 0 flag missed");
  // Counter 1 wrap reaches the wake-up output
  chk_wake_c1: assert property (@(posedge clk_i) disable iff (rst_i)
    c1.overflow |=> wakeup_o)
    else $error("no wake-up on counter 1 wrap");
  // An enabled counter 0 flag raises the interrupt output
  chk_irq_c0: assert property (@(posedge clk_i) disable iff (rst_i)
    (interrupt_control_register[`DTEC_BIT_T0_FLAG] && interrupt_control_register[`DTEC_BIT_T0_EN]) |=> irq_o)
    else $error("enabled counter 0 flag without irq");
  // An enabled counter 1 flag raises the interrupt output
  chk_irq_c1: assert property (@(posedge clk_i) disable iff (rst_i)
    (interrupt_control_register[`DTEC_BIT_T1_FLAG] && interrupt_control_register[`DTEC_BIT_T1_EN]) |=> irq_o)
    else $error("enabled counter 1 flag without irq");
  // Counter 1 keeps its run bit outside pulse mode
  chk_run_keep1: assert property (@(posedge clk_i) disable iff (rst_i)
    (c1.mode != DTEC_MODE_PULSE && c1.run_bit && !wr) |=> c1.run_bit)
    else $error("counter 1 run cleared without write");
  // Measurement end drops the run bit unless a write lands
  chk_pulse_stop: assert property (@(posedge clk_i) disable iff (rst_i)
    (c0.run_clear && !wr) |=> !c0.run_bit)
    else $error("run bit kept after measurement");
  // Mode output copies the counter 0 mode field
  chk_mode_copy: assert property (@(posedge clk_i) disable iff (rst_i)
    counter0_mode_o == $past(c0.mode))
    else $error("mode output stale");
endmodule : dtec_top

// >>> dtec_consts.svh
// Offsets, control field positions, reset values and timing for the dual counter.
// Assumes a byte-wide register file on classic Wishbone; included by bare name.
`ifndef DTEC_CONSTS_SVH
`define DTEC_CONSTS_SVH
`define DTEC_ADR_C0_DATA 8'h0D
`define DTEC_ADR_C0_CTRL 8'h0E
`define DTEC_ADR_C1_HIGH 8'h0F
`define DTEC_ADR_C1_LOW 8'h10
`define DTEC_ADR_C1_CTRL 8'h11
`define DTEC_ADR_INTERRUPT_CONTROL_REGISTER 8'h12
`define DTEC_BIT_EDGE 3
`define DTEC_BIT_RUN 4
`define DTEC_BIT_MODE_LO 6
`define DTEC_BIT_MODE_HI 7
`define DTEC_CTRL_MASK 8'hD8
`define DTEC_CTRL_RESET 8'h08
`define DTEC_INTERRUPT_CONTROL_REGISTER_MASK 8'h6C
`define DTEC_BIT_T0_EN 2
`define DTEC_BIT_T1_EN 3
`define DTEC_BIT_T0_FLAG 5
`define DTEC_BIT_T1_FLAG 6
`define DTEC_PRESCALE 4
`endif

// >>> dtec_pkg.sv
// Types shared by the dual counter modules.
// Assumes the constants header is compiled alongside.
package dtec_pkg;
  // Operating mode field
  typedef enum logic [1:0] {
    DTEC_MODE_NONE = 2'h0,
    DTEC_MODE_EVENT = 2'h1,
    DTEC_MODE_TIMER = 2'h2,
    DTEC_MODE_PULSE = 2'h3
  } dtec_mode_t;
  // Pulse measurement states, one-hot
  typedef enum logic [2:0] {
    DTEC_PW_ARMED = 3'h1,
    DTEC_PW_MEASURE = 3'h2,
    DTEC_PW_DONE = 3'h4
  } dtec_pw_t;
endpackage : dtec_pkg

// >>> dtec_cnt_if.sv
// Control and status bundle between the register top and one counter core.
// Assumes one instance per counter, all on the system clock.
interface dtec_cnt_if #(parameter int W = 8);
  logic [1:0] mode;      // Mode field
  logic edge_select;     // 1 = falling edge active
  logic run_bit;         // Counting enabled
  logic load_stb;        // Preload written while stopped
  logic [W-1:0] preload; // Reload value
  logic freeze;          // Count clock blocked during a read
  logic [W-1:0] count;   // Live counter
  logic overflow;        // One-cycle overflow pulse
  logic run_clear;       // One-cycle pulse: measurement finished
  modport top (output mode, edge_select, run_bit, load_stb, preload, freeze,
               input count, overflow, run_clear);
  modport core (input mode, edge_select, run_bit, load_stb, preload, freeze,
                output count, overflow, run_clear);
endinterface : dtec_cnt_if

// >>> dtec_core.sv
// One count-up counter with event, timer and single-shot pulse-width modes.
// Assumes the pin is synchronous to clk_i; the divide-by-four tick is local.
`include "dtec_consts.svh"
module dtec_core #(parameter int W = 8) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  dtec_cnt_if.core cif
);
  import dtec_pkg::*;
  logic [1:0] pre;       // System clock prescaler
  logic pin_q;           // Previous pin level
  logic [W-1:0] count;
  dtec_pw_t pw;
  logic tick;
  logic rise;
  logic fall;
  logic act_edge;
  logic ret_edge;
  logic step;
  logic [W-1:0] next_count;
  logic at_top;

  assign tick = (pre == 2'(`DTEC_PRESCALE - 1));
  assign rise = pin_i & ~pin_q;
  assign fall = ~pin_i & pin_q;
  assign act_edge = cif.edge_select ? fall : rise;
  assign ret_edge = cif.edge_select ? rise : fall;
  assign at_top = &count;

  // Count enable per mode, blocked while software reads
  always_comb begin
    case (cif.mode)
      DTEC_MODE_EVENT: step = cif.run_bit & act_edge;
      DTEC_MODE_TIMER: step = cif.run_bit & tick;
      DTEC_MODE_PULSE: step = cif.run_bit & tick & (pw == DTEC_PW_MEASURE);
      default: step = 1'b0;
    endcase
    if (cif.freeze) begin
      step = 1'b0;
    end
  end

  // Wrap reloads from preload
  assign next_count = at_top ? cif.preload : W'(count + 1'b1);

  // Prescaler and pin history
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre <= 2'h0;
      pin_q <= 1'b0;
    end else begin
      pre <= 2'(pre + 2'h1);
      pin_q <= pin_i;
    end
  end

  // Counter register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= '0;
    end else if (cif.load_stb) begin
      count <= cif.preload;
    end else if (step) begin
      count <= next_count;
    end
  end

  // Pulse measurement sequencer: armed, measuring, done
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pw <= DTEC_PW_ARMED;
    end else if (cif.mode != DTEC_MODE_PULSE || !cif.run_bit) begin
      pw <= DTEC_PW_ARMED;
    end else begin
      case (pw)
        DTEC_PW_ARMED: if (act_edge) pw <= DTEC_PW_MEASURE;
        DTEC_PW_MEASURE: if (ret_edge) pw <= DTEC_PW_DONE;
        DTEC_PW_DONE: pw <= DTEC_PW_DONE;
        default: pw <= DTEC_PW_ARMED;
      endcase
    end
  end

  // Overflow pulse back to the register top
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cif.overflow <= 1'b0;
    end else begin
      cif.overflow <= step & at_top & ~cif.load_stb;
    end
  end
  // Measurement end reaches the top at the same edge, so a control write there wins
  assign cif.run_clear = (pw == DTEC_PW_MEASURE) & ret_edge & cif.run_bit
                         & (cif.mode == DTEC_MODE_PULSE);
  assign cif.count = count;

  chk_pulse_done: assert property (@(posedge clk_i) disable iff (rst_i)
    cif.run_clear |-> ##1 (pw == DTEC_PW_DONE || pw == DTEC_PW_ARMED))
    else $error("measurement end without done state");
  chk_freeze_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (cif.freeze && !cif.load_stb) |=> (count == $past(count)))
    else $error("count moved during read");
  chk_wrap_reload: assert property (@(posedge clk_i) disable iff (rst_i)
    (step && at_top && !cif.load_stb) |=> (count == $past(cif.preload)))
    else $error("no reload on wrap");
  chk_done_static: assert property (@(posedge clk_i) disable iff (rst_i)
    (pw == DTEC_PW_DONE && !cif.load_stb) |=> (count == $past(count)))
    else $error("count moved after measurement");
endmodule : dtec_core

// >>> dtec_pin_src.sv
// External pulse source for one counter input pin.
// Assumes the bench clock; the pin idles low and changes just after rising edges.
module dtec_pin_src (
  input wire logic clk_i,
  output logic pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle level until a scenario asks for pulses
  initial pin_o = 1'b0;
  // Send n pulses, each hi cycles high then lo cycles low, plus one more low cycle before the next pulse
  task automatic pulses(input int n, input int hi, input int lo);
    repeat (n) begin
      @(posedge clk_i);
      pin_o <= 1'b1;
      repeat (hi) @(posedge clk_i);
      pin_o <= 1'b0;
      repeat (lo) @(posedge clk_i);
    end
  endtask : pulses
endmodule : dtec_pin_src

// >>> dual_timer_event_counter_tb.sv
// Self-checking bench for the dual counter: Wishbone master, two pin sources, models.
// Assumes the design files and the constants header are compiled first.
module dual_timer_event_counter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dtec_pkg::*;
  logic clk_i = 1'b0; // System clock
  logic rst_i = 1'b1; // Sync reset
  logic cyc = 1'b0; // Bus request
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h1; // Low lane only
  logic [31:0] dat = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic irq_o;
  logic wakeup_o;
  dtec_mode_t mode0;
  logic pin0;
  logic pin1;
  logic [7:0] q; // Last read data
  logic [7:0] lo;
  logic [7:0] hi;
  int bad_count = 0;
  int tests_run = 0;
  int seed = 8;
  int wk = 0; // Wake-up pulses seen
  int exp1; // Model of counter 1
  int n;
  int hits;
  dtec_top dtec_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .counter0_input_pin_i(pin0), .counter1_input_pin_i(pin1),
    .irq_o(irq_o), .wakeup_o(wakeup_o), .counter0_mode_o(mode0));
  dtec_pin_src src0 (.clk_i(clk_i), .pin_o(pin0));
  dtec_pin_src src1 (.clk_i(clk_i), .pin_o(pin1));
  // Clock at 50 MHz
  always #10 clk_i = ~clk_i;
  // Count wake-up pulses
  always @(posedge clk_i) begin
    if (wakeup_o === 1'b1) wk++;
  end
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
    tests_run++;
    if (seen !== e) begin
      bad_count++;
      $display("unexpected %s exp %h seen %h", nm, e, seen);
    end
  endtask : chk
  // One classic Wishbone cycle, held until ack
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    chk("ack wait", k, 2);
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk($sformatf("reg %h", a), q, e);
  endtask : rd
  // Verdict
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h0E, 8'h08);
    rd(8'h11, 8'h08);
    rd(8'h12, 8'h00);
    rd(8'h20, 8'h00);
    wr(8'h11, 8'h27);
    rd(8'h11, 8'h00);
    // Counter 0 timer, overflow, masking
    wr(8'h0D, 8'hFC);
    rd(8'h0D, 8'hFC);
    wr(8'h12, 8'h04);
    wr(8'h0E, 8'h90);
    repeat (2) @(posedge clk_i);
    chk("mode0", mode0, DTEC_MODE_TIMER);
    n = 0;
    while (irq_o !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    chk("irq", irq_o, 1'b1);
    rd(8'h12, 8'h24);
    rd(8'h0E, 8'h90);
    wr(8'h0D, 8'hF8);
    wr(8'h12, 8'h00);
    repeat (2) @(posedge clk_i);
    hits = 0;
    repeat (60) begin
      @(posedge clk_i);
      if (irq_o !== 1'b0) hits++;
    end
    chk("irq masked", hits, 0);
    rd(8'h12, 8'h20);
    chk("wakeups", wk >= 3, 1);
    wr(8'h0E, 8'h00);
    // Counter 1 buffered access and event counting on both edges
    lo = 8'($random(seed));
    hi = 8'($random(seed)) & 8'h7F;
    wr(8'h10, lo);
    wr(8'h0F, hi);
    rd(8'h0F, hi);
    rd(8'h10, lo);
    exp1 = {hi, lo};
    for (int e = 0; e < 2; e++) begin
      n = 2 + ($random(seed) & 7);
      wr(8'h11, 8'(8'h50 + 8 * e));
      src1.pulses(n, 5, 5);
      repeat (4) @(posedge clk_i);
      wr(8'h11, 8'(8'h40 + 8 * e));
      exp1 += n;
      rd(8'h0F, 8'(exp1 >> 8));
      rd(8'h10, 8'(exp1));
    end
    // Counter 1 timer wrap: flag and interrupt
    wr(8'h10, 8'hFC);
    wr(8'h0F, 8'hFF);
    wr(8'h12, 8'h08);
    wr(8'h11, 8'h90);
    n = 0;
    while (irq_o !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    chk("irq1", irq_o, 1'b1);
    wr(8'h11, 8'h00);
    rd(8'h0F, 8'hFF);
    rd(8'h12, 8'h48);
    // Counter 0 single-shot width, rising then falling start edge
    for (int e = 0; e < 2; e++) begin
      wr(8'h0D, 8'h00);
      wr(8'h0E, 8'(8'hD0 + 8 * e));
      src0.pulses(1 + e, e ? 8 : 40, e ? 40 : 10);
      rd(8'h0E, 8'(8'hC0 + 8 * e));
      xfer(1'b0, 8'h0D, 8'h00);
      chk("width", q >= 8'h0A && q <= 8'(8'h0A + e), 1'b1);
    end
    tally_and_finish();
  end
endmodule : dual_timer_event_counter_tb
